//--- design/clock_gate_consts.vh
`ifndef CLOCK_GATE_CONSTS_VH
`define CLOCK_GATE_CONSTS_VH
// register byte offsets inside the system control space
`define RUN_GATE_OFF        12'h104
`define SLEEP_GATE_OFF      12'h114
`define DEEP_GATE_OFF       12'h124
`define RUN_CFG_OFF         12'h060
`define IRQ_STATUS_OFF      12'h130
`define IRQ_MASK_OFF        12'h134
// writable gating bits; all other bits are reserved, read as zero
`define GATE_WR_MASK        32'h030F5037
`define GATE_RESET          32'h00000000
// automatic gating select bit in the run clock configuration register
`define AUTO_GATE_BIT       27
`define RUN_CFG_MASK        32'h08000000
// interrupt status bit positions
`define IRQ_FAULT_BIT       0
`define IRQ_DEEP_BIT        1
`define IRQ_MASK_BITS       32'h00000003
// axi response codes
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2
// power modes presented to the selector
`define MODE_RUN            2'h0
`define MODE_SLEEP          2'h1
`define MODE_DEEP           2'h2
`endif

//--- design/gate_select.v
`timescale 1ns/10ps
`default_nettype none
`include "clock_gate_consts.vh"
// picks the gating word that applies in the present power mode
module gate_select (
  // power mode and selection
  input  wire [1:0]  powerMode,
  input  wire        autoGate,
  // the three gating words
  input  wire [31:0] runGate,
  input  wire [31:0] sleepGate,
  input  wire [31:0] deepGate,
  // resulting enables
  output reg  [31:0] activeGate
);
  // sleep copies only count when automatic gating is selected
  always @* begin
    activeGate = runGate;
    if (autoGate) begin
      case (powerMode)
        `MODE_SLEEP: activeGate = sleepGate;
        `MODE_DEEP:  activeGate = deepGate;
        default:     activeGate = runGate;
      endcase
    end
  end
endmodule // gate_select
`default_nettype wire

//--- design/deep_sleep_clock_gating.v
// Overview of operation
// - set bit clocks a unit, clear bit stops it
// - access to unclocked unit raises bus fault while ce is high
// - reset clears every gating bit to zero
// - run, sleep, deep-sleep copies share one layout
// - sleep copies apply only with auto gating
// - bits 25 and 24 gate the comparators
`timescale 1ns/10ps
`default_nettype none
`include "clock_gate_consts.vh"
module deep_sleep_clock_gating (
  // clock, reset, enable
  input  wire        clk,
  input  wire        rst_n,
  input  wire        ce,
  // axi4-lite write address
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // axi4-lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // power mode from the system controller, same clock
  input  wire        sleepMode,
  input  wire        deepSleepMode,
  // peripheral access check
  input  wire        periphAccess,
  input  wire [4:0]  periphIndex,
  output reg         busFault,
  // per-unit clock enables and interrupt
  output reg  [31:0] clkEnable,
  output wire        irq
);
  // software-visible state
  reg  [31:0] runGate_q;     // run copy
  reg  [31:0] sleepGate_q;   // sleep copy
  reg  [31:0] deepGate_q;    // deep-sleep copy
  reg  [31:0] runCfg_q;      // holds the auto gating select bit
  reg  [31:0] irqStatus_q;   // sticky events
  reg  [31:0] irqMask_q;     // event enables
  // write channel holding state
  reg         awHeld_q;      // address captured
  reg         wHeld_q;       // data captured
  reg  [11:0] awAddr_q;      // captured address
  reg  [31:0] wData_q;       // captured data
  reg  [3:0]  wStrb_q;       // captured strobes
  reg         deepPrev_q;    // for deep-sleep entry edge
  wire [31:0] activeGate;    // word for the present mode
  wire [1:0]  powerMode;     // encoded mode
  wire        doWrite;       // both halves present
  reg  [31:0] readData;      // read mux result
  reg         readHit;       // read address mapped
  reg         writeHit;      // write address mapped
  wire        faultEvent;    // gated unit touched
  wire        deepEvent;     // deep-sleep entered
  reg  [31:0] irqEvents;     // events of this cycle at their status bits
  // merge strobed bytes of new data over old, keep only legal bits
  function [31:0] merge;
    input [31:0] oldVal;
    input [31:0] newVal;
    input [3:0]  strb;
    input [31:0] legal;
    integer i;
    reg [31:0] tmp;
    begin
      tmp = oldVal;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          tmp[i*8 +: 8] = newVal[i*8 +: 8];
        end
      end
      merge = tmp & legal;
    end
  endfunction
  // deep-sleep outranks sleep when both are asserted
  assign powerMode = deepSleepMode ? `MODE_DEEP :
                     (sleepMode ? `MODE_SLEEP : `MODE_RUN);
  gate_select u_sel (
    .powerMode  (powerMode),
    .autoGate   (runCfg_q[`AUTO_GATE_BIT]),
    .runGate    (runGate_q),
    .sleepGate  (sleepGate_q),
    .deepGate   (deepGate_q),
    .activeGate (activeGate)
  );
  // a channel stays ready until its half is captured and the
  // response is returned, so one write at a time is under way;
  // readies drop while ce is low, so no request is lost in a freeze;
  // a response is only retired with ce high, so a master must not
  // take one while the block is frozen
  assign s_axi_awready = ce & ~awHeld_q & ~s_axi_bvalid;
  assign s_axi_wready  = ce & ~wHeld_q & ~s_axi_bvalid;
  assign s_axi_arready = ce & ~s_axi_rvalid;
  assign doWrite       = awHeld_q & wHeld_q & ~s_axi_bvalid;
  assign faultEvent    = periphAccess & ~clkEnable[periphIndex];
  assign deepEvent     = deepSleepMode & ~deepPrev_q;
  assign irq           = |(irqStatus_q & irqMask_q);
  // write address decode
  always @* begin
    case (awAddr_q)
      `RUN_GATE_OFF, `SLEEP_GATE_OFF, `DEEP_GATE_OFF,
      `RUN_CFG_OFF, `IRQ_STATUS_OFF, `IRQ_MASK_OFF: writeHit = 1'b1;
      default: writeHit = 1'b0; // unmapped answers slverr
    endcase
  end
  // read mux; reserved bits are zero because storage never holds them
  always @* begin
    readHit = 1'b1;
    case (s_axi_araddr)
      `RUN_GATE_OFF:   readData = runGate_q;
      `SLEEP_GATE_OFF: readData = sleepGate_q;
      `DEEP_GATE_OFF:  readData = deepGate_q;
      `RUN_CFG_OFF:    readData = runCfg_q;
      `IRQ_STATUS_OFF: readData = irqStatus_q;
      `IRQ_MASK_OFF:   readData = irqMask_q;
      default: begin
        readData = 32'h00000000;
        readHit  = 1'b0;
      end
    endcase
  end
  // capture write halves in either order
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awHeld_q <= 1'b0;
      wHeld_q  <= 1'b0;
      awAddr_q <= 12'h000;
      wData_q  <= 32'h00000000;
      wStrb_q  <= 4'h0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeld_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end else if (doWrite) begin
        wHeld_q <= 1'b0;
      end
    end
  end
  // write response
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else if (ce) begin
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= writeHit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // read response, one cycle after the address is taken
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= readData;
        s_axi_rresp  <= readHit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  // gating registers; reset leaves every unit unclocked
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      runGate_q   <= `GATE_RESET;
      sleepGate_q <= `GATE_RESET;
      deepGate_q  <= `GATE_RESET;
      runCfg_q    <= 32'h00000000;
      irqMask_q   <= 32'h00000000;
    end else if (ce && doWrite) begin
      // one legal mask covers all copies: same layout everywhere
      case (awAddr_q)
        `RUN_GATE_OFF: runGate_q <=
          merge(runGate_q, wData_q, wStrb_q, `GATE_WR_MASK);
        `SLEEP_GATE_OFF: sleepGate_q <=
          merge(sleepGate_q, wData_q, wStrb_q, `GATE_WR_MASK);
        `DEEP_GATE_OFF: deepGate_q <=
          merge(deepGate_q, wData_q, wStrb_q, `GATE_WR_MASK);
        `RUN_CFG_OFF: runCfg_q <=
          merge(runCfg_q, wData_q, wStrb_q, `RUN_CFG_MASK);
        `IRQ_MASK_OFF: irqMask_q <=
          merge(irqMask_q, wData_q, wStrb_q, `IRQ_MASK_BITS);
        default: ;
      endcase
    end
  end
  // place each event at its status bit position
  always @* begin
    irqEvents                 = 32'h00000000;
    irqEvents[`IRQ_FAULT_BIT] = faultEvent;
    irqEvents[`IRQ_DEEP_BIT]  = deepEvent;
  end
  // sticky status; a new event wins over a same-cycle clear
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irqStatus_q <= 32'h00000000;
    end else if (ce) begin
      irqStatus_q <= (irqStatus_q &
        ~((doWrite && awAddr_q == `IRQ_STATUS_OFF) ?
          (wData_q & `IRQ_MASK_BITS) : 32'h00000000)) |
        irqEvents;
    end
  end
  // enables, fault pulse and mode edge tracking, all registered
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clkEnable  <= 32'h00000000;
      busFault   <= 1'b0;
      deepPrev_q <= 1'b0;
    end else if (ce) begin
      clkEnable  <= activeGate;
      busFault   <= faultEvent;
      deepPrev_q <= deepSleepMode;
    end
  end
endmodule // deep_sleep_clock_gating
`default_nettype wire

//--- dv/clock_gate_sva.sv
`timescale 1ns/10ps
`default_nettype none
`include "clock_gate_consts.vh"
module clock_gate_sva (
  // clock, reset, bus
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        ce,
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  // modes, access check, enables
  input wire logic        sleepMode,
  input wire logic        deepSleepMode,
  input wire logic        periphAccess,
  input wire logic [4:0]  periphIndex,
  input wire logic        busFault,
  input wire logic [31:0] clkEnable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // an access to an unclocked unit with ce high faults on the next cycle
  property p_fault;
    ce && periphAccess && !clkEnable[periphIndex] |=> busFault;
  endproperty
  a_fault: assert property (p_fault) else $error("fault missing");
  // no fault without a cause; a frozen cycle keeps the old value
  property p_cause;
    $past(ce) && busFault |-> $past(periphAccess && !clkEnable[periphIndex]);
  endproperty
  a_cause: assert property (p_cause) else $error("spurious fault");
  // reserved positions never carry an enable
  property p_encRes;
    (clkEnable & ~`GATE_WR_MASK) == 32'h00000000;
  endproperty
  a_encRes: assert property (p_encRes) else $error("reserved enable");
  // reserved bits of the deep copy read back as zero, answer one cycle on
  property p_rdRes;
    $past(s_axi_arvalid && s_axi_arready && ce &&
          s_axi_araddr == `DEEP_GATE_OFF) |->
      s_axi_rvalid && (s_axi_rdata & ~`GATE_WR_MASK) == 32'h00000000;
  endproperty
  a_rdRes: assert property (p_rdRes) else $error("reserved read");
  // first cycle out of reset shows every unit unclocked
  property p_reset;
    !$past(rst_n) |-> clkEnable == 32'h00000000 && !busFault;
  endproperty
  a_reset: assert property (p_reset) else $error("not cleared");
  // enables move only after a register write, a mode change or a thaw
  property p_hold;
    ce && $past(ce) && !s_axi_bvalid && $stable(sleepMode) &&
      $stable(deepSleepMode) |=> $stable(clkEnable);
  endproperty
  a_hold: assert property (p_hold) else $error("enable moved");
  // a low enable freezes the enables and the fault flag
  property p_freeze;
    !ce |=> $stable(clkEnable) && $stable(busFault);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved");
  // answers stand until the master takes them
  property p_bHold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bHold: assert property (p_bHold) else $error("bresp dropped");
  property p_rHold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rHold: assert property (p_rHold) else $error("rdata dropped");
  c_fault: cover property (busFault);
  c_deep: cover property (deepSleepMode && clkEnable != 32'h00000000);
  c_err: cover property (s_axi_bvalid && s_axi_bresp == `RESP_SLVERR);
  c_freeze: cover property (!ce && periphAccess);
endmodule // clock_gate_sva
bind deep_sleep_clock_gating clock_gate_sva clock_gate_sva_inst (
  .clk           (clk),
  .rst_n         (rst_n),
  .ce            (ce),
  .s_axi_araddr  (s_axi_araddr),
  .s_axi_arvalid (s_axi_arvalid),
  .s_axi_arready (s_axi_arready),
  .s_axi_rdata   (s_axi_rdata),
  .s_axi_rvalid  (s_axi_rvalid),
  .s_axi_rready  (s_axi_rready),
  .s_axi_bresp   (s_axi_bresp),
  .s_axi_bvalid  (s_axi_bvalid),
  .s_axi_bready  (s_axi_bready),
  .sleepMode     (sleepMode),
  .deepSleepMode (deepSleepMode),
  .periphAccess  (periphAccess),
  .periphIndex   (periphIndex),
  .busFault      (busFault),
  .clkEnable     (clkEnable)
);
`default_nettype wire

//--- dv/deep_sleep_clock_gating_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "clock_gate_consts.vh"
module deep_sleep_clock_gating_tb;
  logic clk = 1'h0, rst_n = 1'h0, ce = 1'h1;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, run, v;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic sleepMode = 1'h0, deepSleepMode = 1'h0, periphAccess = 1'h0;
  logic [4:0] periphIndex = 5'h0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, busFault, irq;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata, clkEnable;
  int failCount = 0, compares = 0, cycles = 0;
  integer seed = 32'hBA9C;
  logic [33:0] q[$]; // expected {resp, data} of each bus answer
  deep_sleep_clock_gating deep_sleep_clock_gating_inst (
    .clk           (clk),
    .rst_n         (rst_n),
    .ce            (ce),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .sleepMode     (sleepMode),
    .deepSleepMode (deepSleepMode),
    .periphAccess  (periphAccess),
    .periphIndex   (periphIndex),
    .busFault      (busFault),
    .clkEnable     (clkEnable),
    .irq           (irq)
  );
  always #2 clk = ~clk;
  task reportAndStop;
    $display("compares %0d mismatches %0d", compares, failCount);
    if (failCount == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chkSig(input string n, input logic [33:0] e, input logic [33:0] s);
    compares++;
    if (s !== e) begin
      failCount++;
      $display("FAIL %s exp %h got %h", n, e, s);
    end
  endtask
  task chkBus(input logic [33:0] e, input logic [33:0] s);
    chkSig("bus answer", e, s);
  endtask
  // watcher: takes the oldest note at each response handshake
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failCount++;
      reportAndStop;
    end
    if (s_axi_bvalid && s_axi_bready)
      chkBus(q.pop_front(), {s_axi_bresp, 32'h00000000});
    if (s_axi_rvalid && s_axi_rready)
      chkBus(q.pop_front(), {s_axi_rresp, s_axi_rdata});
  end
  // write: both halves offered together, response accepted after a stall
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    logic ta, tw;
    q.push_back({r, 32'h0});
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(negedge clk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      @(posedge clk);
      s_axi_awvalid <= s_axi_awvalid & ~ta;
      s_axi_wvalid <= s_axi_wvalid & ~tw;
    end while ((s_axi_awvalid & ~ta) | (s_axi_wvalid & ~tw));
    repeat ($random(seed) & 3) @(posedge clk);
    s_axi_bready <= 1'h1;
    do @(negedge clk); while (!s_axi_bvalid);
    @(posedge clk);
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    logic t;
    q.push_back(e);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do begin
      @(negedge clk);
      t = s_axi_arready;
      @(posedge clk);
    end while (!t);
    s_axi_arvalid <= 1'h0;
    repeat ($random(seed) & 3) @(posedge clk);
    s_axi_rready <= 1'h1;
    do @(negedge clk); while (!s_axi_rvalid);
    @(posedge clk);
    s_axi_rready <= 1'h0;
  endtask
  // one access pulse, fault looked at in the cycle after it
  task pa(input logic [4:0] i, input logic e);
    @(posedge clk);
    periphIndex <= i;
    periphAccess <= 1'h1;
    @(posedge clk);
    periphAccess <= 1'h0;
    @(negedge clk);
    chkSig("busFault", e, busFault);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    rd(`DEEP_GATE_OFF, 34'h0);
    // upper two byte lanes only: the lower half must stay clear
    s_axi_wstrb <= 4'hC;
    wr(`DEEP_GATE_OFF, 32'hFFFFFFFF, `RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rd(`DEEP_GATE_OFF, {`RESP_OKAY, `GATE_WR_MASK & 32'hFFFF0000});
    wr(`DEEP_GATE_OFF, 32'hFFFFFFFF, `RESP_OKAY);
    rd(`DEEP_GATE_OFF, {`RESP_OKAY, `GATE_WR_MASK});
    repeat (4) begin
      run = $random(seed);
      wr(`RUN_GATE_OFF, run, `RESP_OKAY);
      rd(`RUN_GATE_OFF, {`RESP_OKAY, run & `GATE_WR_MASK});
    end
    chkSig("clkEnable", run & `GATE_WR_MASK, clkEnable);
    @(posedge clk);
    deepSleepMode <= 1'h1;
    repeat (3) @(negedge clk);
    chkSig("clkEnable", run & `GATE_WR_MASK, clkEnable);
    wr(`RUN_CFG_OFF, `RUN_CFG_MASK, `RESP_OKAY);
    repeat (2) @(negedge clk);
    chkSig("clkEnable", `GATE_WR_MASK, clkEnable);
    v = $random(seed) & `GATE_WR_MASK;
    wr(`DEEP_GATE_OFF, v, `RESP_OKAY);
    wr(`IRQ_MASK_OFF, 32'h1, `RESP_OKAY);
    for (int i = 0; i < 32; i++) pa(i[4:0], !v[i]);
    chkSig("irq", 1'h1, irq);
    wr(`IRQ_STATUS_OFF, 32'h1, `RESP_OKAY);
    chkSig("irq", 1'h0, irq);
    rd(`IRQ_STATUS_OFF, {`RESP_OKAY, 32'h2});
    wr(`IRQ_MASK_OFF, 32'h0, `RESP_OKAY);
    pa(5'h3, 1'h1);
    chkSig("irq", 1'h0, irq);
    @(posedge clk);
    deepSleepMode <= 1'h0;
    sleepMode <= 1'h1;
    repeat (3) @(negedge clk);
    chkSig("clkEnable", 34'h0, clkEnable);
    // freeze with the bus idle: enables and fault flag must hold
    @(posedge clk);
    ce <= 1'h0;
    sleepMode <= 1'h0;
    repeat (3) @(negedge clk);
    chkSig("clkEnable", 34'h0, clkEnable);
    pa(5'h3, 1'h0);
    @(posedge clk);
    ce <= 1'h1;
    repeat (2) @(negedge clk);
    chkSig("clkEnable", run & `GATE_WR_MASK, clkEnable);
    wr(12'h200, 32'hFFFFFFFF, `RESP_SLVERR);
    rd(12'h126, {`RESP_SLVERR, 32'h0});
    @(posedge clk);
    rst_n <= 1'h0;
    @(posedge clk);
    rst_n <= 1'h1;
    rd(`DEEP_GATE_OFF, 34'h0);
    reportAndStop;
  end
endmodule // deep_sleep_clock_gating_tb
`default_nettype wire
